// [rtl/els_defines.svh]
// constants for the exception and low-power sequencer
`ifndef ELS_DEFINES_SVH
`define ELS_DEFINES_SVH
`define ELS_ADDR_BWS 5'h00
`define ELS_ADDR_RSR 5'h04
`define ELS_ADDR_BFC 5'h08
`define ELS_ADDR_CFG 5'h0C
`define ELS_ADDR_BRX 5'h10
`define ELS_BIT_BW 1
`define ELS_BIT_BREAK_FLAG_CLEAR_ENABLE 7
`define ELS_BIT_SHORT_RECOVERY_BIT 0
`define ELS_BIT_WDD 1
`define ELS_REC_LONG 12'hFFF
`define ELS_REC_SHORT 12'h01F
`define ELS_NIRQ 8
`define ELS_RSR_POR 6'h01
`endif

// [rtl/els_pkg.sv]
// types for the exception and low-power sequencer
package els_pkg;
  typedef enum logic [2:0] {
    ELS_RUN, ELS_ENTRY, ELS_WAIT, ELS_STOP, ELS_RECOVER
  } els_state_t;
  typedef struct packed {
    logic [7:0] req;
    logic [7:0] en;
  } els_irq_t;
  typedef struct packed {
    logic [11:0] cnt;
    logic running;
    logic done;
  } els_rec_t;
endpackage

// [rtl/els_arbiter.sv]
// fixed priority arbiter, bit 0 highest
`timescale 1ns/10ps
`include "els_defines.svh"
module els_arbiter (
  input wire logic [7:0] pend_in,
  output logic hit_out,
  output logic [2:0] idx_out
);
  always_comb begin
    hit_out = |pend_in;
    idx_out = 3'h0;
    for (int i = `ELS_NIRQ - 1; i >= 0; i--) begin
      if (pend_in[i]) begin
        idx_out = i[2:0];
      end
    end
  end
endmodule

// [rtl/els_recovery.sv]
// stop recovery counter, cleared during stop
`timescale 1ns/10ps
`include "els_defines.svh"
module els_recovery (
  input wire logic mclk_in,
  input wire logic resetn_in,
  input wire logic hold_in,
  input wire logic start_in,
  input wire logic short_in,
  output els_pkg::els_rec_t rec_out
);
  els_pkg::els_rec_t st, next_st;
  always_comb begin
    next_st = st;
    next_st.done = 1'b0;
    if (hold_in) begin
      next_st.cnt = 12'h000;
      next_st.running = 1'b0;
    end else if (start_in) begin
      next_st.cnt = 12'h000;
      next_st.running = 1'b1;
    end else if (st.running) begin
      if (st.cnt == (short_in ? `ELS_REC_SHORT : `ELS_REC_LONG)) begin
        next_st.running = 1'b0;
        next_st.done = 1'b1;
      end else begin
        next_st.cnt = st.cnt + 12'h001;
      end
    end else begin
      next_st.cnt = st.cnt + 12'h001;
    end
  end
  always_ff @(posedge mclk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end
  assign rec_out = st;
endmodule

// [rtl/els_sequencer.sv]
// exception arbitration and low-power sequencing with apb registers
`timescale 1ns/10ps
`include "els_defines.svh"
module els_sequencer (
  input wire logic mclk_in,
  input wire logic resetn_in,
  input wire logic psel_in,
  input wire logic penable_in,
  input wire logic pwrite_in,
  input wire logic [4:0] paddr_in,
  input wire logic [31:0] pwdata_in,
  output logic [31:0] prdata_out,
  output logic pready_out,
  output logic pslverr_out,
  input wire els_pkg::els_irq_t irq_in,
  input wire logic insn_done_in,
  input wire logic imask_in,
  input wire logic swi_in,
  input wire logic wait_insn_in,
  input wire logic stop_insn_in,
  input wire logic break_in,
  input wire logic [5:0] reset_cause_in,
  input wire logic por_in,
  input wire logic [1:0] step1_in,
  input wire logic [1:0] step2_in,
  output logic take_int_out,
  output logic [3:0] vector_out,
  output logic pc_minus1_out,
  output logic stack_h_out,
  output logic clr_imask_out,
  output logic cpu_clk_en_out,
  output logic periph_clk_en_out,
  output logic sys_clk_en_out,
  output logic xtal_en_out,
  output logic watchdog_run_out,
  output logic break_active_out,
  output logic break_unit_en_out,
  output logic flag_clr_allow_out,
  output logic [1:0] flag_clr_out
);
  typedef struct packed {
    els_pkg::els_state_t state;
    logic bw;
    logic [5:0] rsr;
    logic break_flag_clear_enable;
    logic short_recovery_bit;
    logic wdd;
    logic in_break;
    logic take;
    logic [3:0] vec;
    logic pcm1;
    logic [1:0] armed;
    logic [1:0] clr;
    logic [31:0] rdata;
  } els_state_struct_t;
  els_state_struct_t s, next_s;
  els_pkg::els_rec_t rec;
  logic [7:0] pend;
  logic hit;
  logic [2:0] idx;
  logic acc, wr, rd, mapped, setup_rd;
  // enabled requests, mask already cleared in low power
  assign pend = irq_in.req & irq_in.en &
                {8{~imask_in | (s.state != els_pkg::ELS_RUN)}};
  els_arbiter u_arb (
    .pend_in(pend),
    .hit_out(hit),
    .idx_out(idx)
  );
  els_recovery u_rec (
    .mclk_in(mclk_in),
    .resetn_in(resetn_in),
    .hold_in(next_s.state == els_pkg::ELS_STOP),
    .start_in(next_s.state == els_pkg::ELS_RECOVER &&
              s.state == els_pkg::ELS_STOP),
    .short_in(s.short_recovery_bit),
    .rec_out(rec)
  );
  function automatic logic hit_addr(input logic [4:0] a,
    input logic [4:0] b);
    hit_addr = (a == b);
  endfunction
  assign acc = psel_in & penable_in;
  assign wr = acc & pwrite_in;
  assign rd = acc & ~pwrite_in;
  assign setup_rd = psel_in & ~penable_in & ~pwrite_in;
  assign mapped = hit_addr(paddr_in, `ELS_ADDR_BWS) |
                  hit_addr(paddr_in, `ELS_ADDR_RSR) |
                  hit_addr(paddr_in, `ELS_ADDR_BFC) |
                  hit_addr(paddr_in, `ELS_ADDR_CFG) |
                  (hit_addr(paddr_in, `ELS_ADDR_BRX) & s.in_break);
  always_comb begin
    next_s = s;
    next_s.take = 1'b0;
    next_s.clr = 2'b00;
    // latch the cause on any reset
    if (|reset_cause_in) begin
      next_s.rsr = reset_cause_in;
    end
    // power-on leaves only its own flag
    if (por_in) begin
      next_s.rsr = `ELS_RSR_POR;
    end
    unique case (s.state)
      els_pkg::ELS_RUN: begin
        if (insn_done_in) begin
          if (break_in) begin
            next_s.take = 1'b1;
            next_s.vec = 4'hF;
            next_s.pcm1 = 1'b0;
            next_s.in_break = 1'b1;
          end else if (swi_in) begin
            next_s.take = 1'b1;
            next_s.vec = 4'hF;
            next_s.pcm1 = 1'b0;
          end else if (hit) begin
            next_s.take = 1'b1;
            next_s.vec = {1'b0, idx};
            next_s.pcm1 = 1'b1;
          end else if (stop_insn_in) begin
            next_s.state = els_pkg::ELS_STOP;
          end else if (wait_insn_in) begin
            next_s.state = els_pkg::ELS_WAIT;
          end
        end
      end
      els_pkg::ELS_WAIT: begin
        if (break_in) begin
          next_s.bw = 1'b1;
          next_s.take = 1'b1;
          next_s.vec = 4'hF;
          next_s.pcm1 = 1'b0;
          next_s.in_break = 1'b1;
          next_s.state = els_pkg::ELS_RUN;
        end else if (|(irq_in.req & irq_in.en)) begin
          next_s.take = 1'b1;
          next_s.vec = {1'b0, idx};
          next_s.pcm1 = 1'b1;
          next_s.state = els_pkg::ELS_RUN;
        end
      end
      els_pkg::ELS_STOP: begin
        if (|(irq_in.req & irq_in.en) || break_in) begin
          next_s.state = els_pkg::ELS_RECOVER;
          next_s.in_break = break_in;
        end
      end
      els_pkg::ELS_RECOVER: begin
        if (rec.done) begin
          next_s.take = 1'b1;
          next_s.vec = s.in_break ? 4'hF : {1'b0, idx};
          next_s.pcm1 = ~s.in_break;
          next_s.state = els_pkg::ELS_RUN;
        end
      end
      default: begin
        next_s.state = els_pkg::ELS_RUN;
      end
    endcase
    next_s.armed = s.armed | step1_in;
    if (!s.in_break || s.break_flag_clear_enable) begin
      next_s.clr = s.armed & step2_in;
      next_s.armed = (s.armed | step1_in) & ~(s.armed & step2_in);
    end
    if (wr) begin
      if (hit_addr(paddr_in, `ELS_ADDR_BWS) &&
          !pwdata_in[`ELS_BIT_BW] && !(s.state == els_pkg::ELS_WAIT &&
          break_in)) begin
        next_s.bw = 1'b0;
      end
      if (hit_addr(paddr_in, `ELS_ADDR_BFC)) begin
        next_s.break_flag_clear_enable = pwdata_in[`ELS_BIT_BREAK_FLAG_CLEAR_ENABLE];
        if (!pwdata_in[`ELS_BIT_BREAK_FLAG_CLEAR_ENABLE] && s.in_break) begin
          next_s.in_break = s.in_break;
        end
      end
      if (hit_addr(paddr_in, `ELS_ADDR_CFG)) begin
        next_s.short_recovery_bit = pwdata_in[`ELS_BIT_SHORT_RECOVERY_BIT];
        next_s.wdd = pwdata_in[`ELS_BIT_WDD];
      end
      if (hit_addr(paddr_in, `ELS_ADDR_BRX) && s.in_break) begin
        next_s.in_break = 1'b0;
      end
    end
    next_s.rdata = 32'h0000_0000;
    // read data registered in the setup cycle
    if (setup_rd) begin
      if (hit_addr(paddr_in, `ELS_ADDR_BWS)) begin
        next_s.rdata[`ELS_BIT_BW] = s.bw;
      end
      if (hit_addr(paddr_in, `ELS_ADDR_RSR)) begin
        next_s.rdata[5:0] = s.rsr;
      end
      if (hit_addr(paddr_in, `ELS_ADDR_BFC)) begin
        next_s.rdata[`ELS_BIT_BREAK_FLAG_CLEAR_ENABLE] = s.break_flag_clear_enable;
      end
      if (hit_addr(paddr_in, `ELS_ADDR_CFG)) begin
        next_s.rdata[`ELS_BIT_SHORT_RECOVERY_BIT] = s.short_recovery_bit;
        next_s.rdata[`ELS_BIT_WDD] = s.wdd;
      end
    end
    if (rd && hit_addr(paddr_in, `ELS_ADDR_RSR)) begin
      next_s.rsr = 6'h00;
    end
  end
  always_ff @(posedge mclk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      s <= '0;
      s.rsr <= `ELS_RSR_POR;
    end else begin
      s <= next_s;
    end
  end
  assign prdata_out = s.rdata;
  assign pready_out = 1'b1;
  assign pslverr_out = acc & ~mapped;
  assign take_int_out = s.take;
  assign vector_out = s.vec;
  assign pc_minus1_out = s.pcm1;
  // index high byte is never stacked
  assign stack_h_out = 1'b0;
  assign clr_imask_out = s.state == els_pkg::ELS_WAIT ||
                         s.state == els_pkg::ELS_STOP;
  // cpu halted, peripherals run in wait
  assign cpu_clk_en_out = s.state == els_pkg::ELS_RUN;
  assign periph_clk_en_out = s.state == els_pkg::ELS_RUN ||
                             s.state == els_pkg::ELS_WAIT;
  // system and crystal clocks off in stop
  assign sys_clk_en_out = s.state != els_pkg::ELS_STOP &&
                          s.state != els_pkg::ELS_RECOVER;
  assign xtal_en_out = s.state != els_pkg::ELS_STOP;
  // watchdog runs in wait unless disabled
  assign watchdog_run_out = (s.state == els_pkg::ELS_RUN) ||
                            (s.state == els_pkg::ELS_WAIT && !s.wdd);
  assign break_active_out = s.in_break;
  // break unit idle in stop, contents kept
  assign break_unit_en_out = s.state != els_pkg::ELS_STOP;
  assign flag_clr_allow_out = !s.in_break || s.break_flag_clear_enable;
  assign flag_clr_out = s.clr;

  property p_wait_wake;
    @(posedge mclk_in) disable iff (!resetn_in)
      (s.state == els_pkg::ELS_WAIT && !break_in &&
       |(irq_in.req & irq_in.en)) |=> take_int_out && cpu_clk_en_out;
  endproperty
  a_wait_wake: assert property (p_wait_wake)
    else $error("wait wake did not stack next cycle");
  property p_bw_set;
    @(posedge mclk_in) disable iff (!resetn_in)
      (s.state == els_pkg::ELS_WAIT && break_in) |=> s.bw;
  endproperty
  a_bw_set: assert property (p_bw_set)
    else $error("break in wait did not set flag");
  property p_no_mid;
    @(posedge mclk_in) disable iff (!resetn_in)
      (s.state == els_pkg::ELS_RUN && !insn_done_in) |=> !take_int_out;
  endproperty
  a_no_mid: assert property (p_no_mid)
    else $error("interrupt taken mid instruction");
  property p_swi;
    @(posedge mclk_in) disable iff (!resetn_in)
      (s.state == els_pkg::ELS_RUN && insn_done_in && swi_in) |=>
        take_int_out && vector_out == 4'hF && !pc_minus1_out;
  endproperty
  a_swi: assert property (p_swi)
    else $error("software interrupt not taken");
  property p_short;
    @(posedge mclk_in) disable iff (!resetn_in)
      (s.state == els_pkg::ELS_STOP && next_s.state ==
       els_pkg::ELS_RECOVER && s.short_recovery_bit) |=> ##[30:34] take_int_out;
  endproperty
  a_short: assert property (p_short)
    else $error("short recovery length wrong");
  property p_rsr_clr;
    @(posedge mclk_in) disable iff (!resetn_in)
      (rd && paddr_in == `ELS_ADDR_RSR && !por_in &&
       reset_cause_in == 6'h00) |=> s.rsr == 6'h00;
  endproperty
  a_rsr_clr: assert property (p_rsr_clr)
    else $error("reset source not cleared on read");
  property p_prot;
    @(posedge mclk_in) disable iff (!resetn_in)
      (s.in_break && !s.break_flag_clear_enable) |=> flag_clr_out == 2'b00;
  endproperty
  a_prot: assert property (p_prot)
    else $error("flag cleared while protected");
  property p_stop_clk;
    @(posedge mclk_in) disable iff (!resetn_in)
      (s.state == els_pkg::ELS_STOP) |-> !sys_clk_en_out && !xtal_en_out
        && rec.cnt == 12'h000;
  endproperty
  a_stop_clk: assert property (p_stop_clk)
    else $error("clocks or counter active in stop");
  property p_run_break;
    @(posedge mclk_in) disable iff (!resetn_in)
      (s.state == els_pkg::ELS_RUN && insn_done_in && break_in) |=>
        take_int_out && vector_out == 4'hF && break_active_out;
  endproperty
  a_run_break: assert property (p_run_break)
    else $error("break did not force software vector");
  property p_por_only;
    @(posedge mclk_in) disable iff (!resetn_in)
      (por_in && !rd) |=> s.rsr == `ELS_RSR_POR;
  endproperty
  a_por_only: assert property (p_por_only)
    else $error("power-on did not leave only its flag");
  property p_free;
    @(posedge mclk_in) disable iff (!resetn_in)
      (s.in_break && s.break_flag_clear_enable && |(s.armed & step2_in)) |=>
        flag_clr_out != 2'b00;
  endproperty
  a_free: assert property (p_free)
    else $error("flag clear blocked with enable set");
  property p_wait_clk;
    @(posedge mclk_in) disable iff (!resetn_in)
      (s.state == els_pkg::ELS_WAIT) |-> !cpu_clk_en_out &&
        periph_clk_en_out && clr_imask_out;
  endproperty
  a_wait_clk: assert property (p_wait_clk)
    else $error("wrong clock enables in wait");
endmodule

// [sim/els_cpu_model.sv]
// cpu core stand-in issuing instruction completions
`timescale 1ns/10ps
module els_cpu_model (
  input wire logic mclk_in,
  input wire logic resetn_in,
  input wire logic cpu_clk_en_in,
  output logic insn_done_out
);
  logic [1:0] cnt;
  // one instruction per four clocked cycles
  always_ff @(posedge mclk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      cnt <= 2'h0;
      insn_done_out <= 1'b0;
    end else begin
      if (cpu_clk_en_in) cnt <= cnt + 2'h1;
      insn_done_out <= cpu_clk_en_in && (cnt == 2'h3);
    end
  end
endmodule

// [sim/exception_lowpower_sequencer_tb.sv]
// self-checking bench for the exception and low-power sequencer
`timescale 1ns/10ps
`define CHK(nm, ex, got) begin cmp_count++; if ((got) !== (ex)) begin \
n_errors++; $display("[FAIL] %s exp %0h got %0h", nm, ex, got); end end
module exception_lowpower_sequencer_tb;
  logic mclk = 1'b0;
  logic resetn = 1'b0;
  logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [4:0] paddr = 5'h00;
  logic [1:0] s1 = 2'h0, s2 = 2'h0;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  logic pready, pslverr, err, insn_done, take_int, pcm1, stack_h;
  els_pkg::els_irq_t irq = '0;
  logic imask = 1'b0, software_interrupt_instruction = 1'b0, wt = 1'b0, stp = 1'b0, brk = 1'b0;
  logic por = 1'b0;
  logic [5:0] cause = 6'h00;
  logic [3:0] vector;
  logic clr_imask, cpu_en, per_en, sys_en, xtal_en, wd_run;
  logic brk_act, brk_unit, clr_allow;
  logic [1:0] flag_clr;
  int n_errors = 0;
  int cmp_count = 0;
  int n;
  always #50 mclk = ~mclk;
  els_cpu_model els_cpu_model_inst (.mclk_in(mclk), .resetn_in(resetn),
    .cpu_clk_en_in(cpu_en), .insn_done_out(insn_done));
  els_sequencer els_sequencer_inst (.mclk_in(mclk), .resetn_in(resetn),
    .psel_in(psel), .penable_in(penable), .pwrite_in(pwrite),
    .paddr_in(paddr), .pwdata_in(pwdata), .prdata_out(prdata),
    .pready_out(pready), .pslverr_out(pslverr), .irq_in(irq),
    .insn_done_in(insn_done), .imask_in(imask), .swi_in(software_interrupt_instruction),
    .wait_insn_in(wt), .stop_insn_in(stp), .break_in(brk),
    .reset_cause_in(cause), .por_in(por), .step1_in(s1),
    .step2_in(s2), .take_int_out(take_int), .vector_out(vector),
    .pc_minus1_out(pcm1), .stack_h_out(stack_h),
    .clr_imask_out(clr_imask), .cpu_clk_en_out(cpu_en),
    .periph_clk_en_out(per_en), .sys_clk_en_out(sys_en),
    .xtal_en_out(xtal_en), .watchdog_run_out(wd_run),
    .break_active_out(brk_act), .break_unit_en_out(brk_unit),
    .flag_clr_allow_out(clr_allow), .flag_clr_out(flag_clr));
  task automatic apb(input logic w, input logic [4:0] a,
    input logic [31:0] d);
    int k;
    k = 0;
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge mclk);
    penable <= 1'b1;
    do begin @(posedge mclk); k++; end while (pready !== 1'b1 && k < 50);
    if (k >= 50) n_errors++;
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge mclk);
  endtask
  task automatic wait_take(input int lim);
    n = 0;
    do begin @(posedge mclk); n++; end while (take_int !== 1'b1 && n < lim);
  endtask
  task automatic t_regs;
    apb(0, 5'h04, 0); `CHK("rsr por", 32'h01, rd)
    apb(0, 5'h04, 0); `CHK("rsr cleared", 32'h00, rd)
    apb(0, 5'h02, 0); `CHK("unmapped err", 1'b1, err)
    apb(1, 5'h08, 32'h80);
    apb(0, 5'h08, 0); `CHK("break_flag_clear_enable rw", 32'h80, rd)
    apb(1, 5'h08, 32'h0);
  endtask
  task automatic t_rsrc;
    for (int i = 0; i < 6; i++) begin
      cause <= 6'h01 << i;
      @(posedge mclk);
      cause <= 6'h00;
      @(posedge mclk);
      apb(0, 5'h04, 0); `CHK("rsr source", 32'h1 << i, rd)
    end
    cause <= 6'h04;
    por <= 1'b1;
    @(posedge mclk);
    cause <= 6'h00;
    por <= 1'b0;
    @(posedge mclk);
    apb(0, 5'h04, 0); `CHK("rsr por only", 32'h01, rd)
  endtask
  task automatic t_irq;
    irq <= '{req: 8'h0A, en: 8'hFF};
    wait_take(100); `CHK("prio vec", 4'h1, vector)
    `CHK("pc minus one", 1'b1, pcm1)
    `CHK("no h stack", 1'b0, stack_h)
    irq <= '{req: 8'h08, en: 8'hFF};
    wait_take(100); `CHK("pending vec", 4'h3, vector)
    irq <= '{req: 8'h01, en: 8'hFF};
    imask <= 1'b1;
    wait_take(40); `CHK("masked", 1'b0, take_int)
    irq <= '{req: 8'h01, en: 8'h00};
    imask <= 1'b0;
    wait_take(40); `CHK("disabled", 1'b0, take_int)
    irq <= '0;
    imask <= 1'b1;
    software_interrupt_instruction <= 1'b1;
    wait_take(100); `CHK("swi vec", 4'hF, vector)
    `CHK("swi pc", 1'b0, pcm1)
    software_interrupt_instruction <= 1'b0;
    imask <= 1'b0;
  endtask
  task automatic t_stop;
    apb(1, 5'h0C, 32'h1);
    stp <= 1'b1;
    n = 0;
    while (sys_en !== 1'b0 && n < 50) begin @(posedge mclk); n++; end
    stp <= 1'b0;
    `CHK("xtal off", 1'b0, xtal_en)
    `CHK("break unit idle", 1'b0, brk_unit)
    `CHK("mask cleared", 1'b1, clr_imask)
    irq <= '{req: 8'h01, en: 8'h01};
    wait_take(6000); `CHK("short rec", 1'b1, n >= 32 && n <= 36)
    `CHK("stop vec", 4'h0, vector)
    irq <= '0;
    apb(1, 5'h0C, 32'h0);
    stp <= 1'b1;
    n = 0;
    while (sys_en !== 1'b0 && n < 50) begin @(posedge mclk); n++; end
    stp <= 1'b0;
    brk <= 1'b1;
    @(posedge mclk);
    brk <= 1'b0;
    wait_take(6000); `CHK("long rec", 1'b1, n >= 4096 && n <= 4100)
    `CHK("break rec vec", 4'hF, vector)
    apb(1, 5'h10, 32'h0); `CHK("break left", 1'b0, brk_act)
  endtask
  task automatic t_wait;
    wt <= 1'b1;
    n = 0;
    while (cpu_en !== 1'b0 && n < 50) begin @(posedge mclk); n++; end
    wt <= 1'b0;
    `CHK("periph run", 1'b1, per_en)
    `CHK("watchdog run", 1'b1, wd_run)
    brk <= 1'b1;
    wait_take(100); `CHK("break vec", 4'hF, vector)
    `CHK("break take", 1'b1, take_int)
    brk <= 1'b0;
    apb(0, 5'h00, 0); `CHK("break wait", 32'h2, rd)
    `CHK("flags guarded", 1'b0, clr_allow)
    apb(1, 5'h08, 32'h80); `CHK("flags free", 1'b1, clr_allow)
    apb(1, 5'h00, 32'h0);
    apb(0, 5'h00, 0); `CHK("bw cleared", 32'h0, rd)
  endtask
  task automatic pulse2(input logic [1:0] b);
    s2 <= b;
    @(posedge mclk);
    s2 <= 2'h0;
    @(posedge mclk);
  endtask
  task automatic t_flags;
    apb(1, 5'h10, 32'h0); `CHK("wait break left", 1'b0, brk_act)
    apb(1, 5'h08, 32'h0);
    s1 <= 2'h1;
    @(posedge mclk);
    s1 <= 2'h0;
    brk <= 1'b1;
    wait_take(100); `CHK("run break", 1'b1, take_int)
    brk <= 1'b0;
    pulse2(2'h1); `CHK("clear held", 2'h0, flag_clr)
    apb(1, 5'h10, 32'h0);
    pulse2(2'h1); `CHK("clear after", 2'h1, flag_clr)
    apb(1, 5'h08, 32'h80);
    brk <= 1'b1;
    wait_take(100); `CHK("run break vec", 4'hF, vector)
    brk <= 1'b0;
    s1 <= 2'h2;
    @(posedge mclk);
    s1 <= 2'h0;
    pulse2(2'h2); `CHK("clear free", 2'h2, flag_clr)
    apb(1, 5'h10, 32'h0);
    apb(1, 5'h08, 32'h0);
    apb(1, 5'h0C, 32'h2);
    wt <= 1'b1;
    n = 0;
    while (cpu_en !== 1'b0 && n < 50) begin @(posedge mclk); n++; end
    wt <= 1'b0;
    `CHK("watchdog off", 1'b0, wd_run)
    irq <= '{req: 8'h04, en: 8'h04};
    wait_take(10); `CHK("irq wake", 4'h2, vector)
    `CHK("irq wake pc", 1'b1, pcm1)
    irq <= '0;
  endtask
  task automatic complete_run;
    $display("errors %0d compares %0d", n_errors, cmp_count);
    if (n_errors == 0 && cmp_count > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask
  initial begin
    #(100 * 30000);
    n_errors++;
    complete_run;
  end
  initial begin
    repeat (16) @(posedge mclk);
    resetn <= 1'b1;
    @(posedge mclk);
    t_regs;
    t_rsrc;
    t_irq;
    t_stop;
    t_wait;
    t_flags;
    complete_run;
  end
endmodule
